// File: verilog/fdi_regs_top.sv
/*
 * Two-wire target (address 30h) and control register bank of a flash LED driver.
 * Link side runs on clk_link, oversampling SCL/SDA; the bank runs on clk_sys.
 * Assumes clk_link is free running and well above 16x the SCL rate, and that
 * the protection detectors deliver faults as levels (async) or clk_sys pulses.
 */
// Overview of operation
// - The bus follows fast-mode timing at up to 400 kbit/s.
// - A repeated start between subaddress and read address is accepted without a stop.
// - Single-byte and multi-byte reads and writes work within one transaction.
// - The first byte after any start is the address and only a match gets a reply.
// - The device answers to address 0110000b, i.e. 60h for write and 61h for read.
// - The first byte after a write address is the register subaddress.
// - Each received data byte is acknowledged and the subaddress then advances.
// - Main level 0 is off, 1 to 11 torch, 12 to 31 armed flash.
// - Indicator current is the 3-bit field times 2.5 mA.
// - Timer bit 4 picks limit or timed mode and bits 3 to 0 pick the duration.
// - Register 03h holds read-only short, temperature, time-out and overvoltage flags.
// - The flash trigger bit clears itself when the flash strobe ends, unless register 02h is written in that same cycle.
// - Any set flag stops the converter and pulls the interrupt line low.
// - Writing 00h to register 00h clears every flag whose fault is absent in that cycle, and frees the interrupt line once none is left set.
`timescale 1ns/1ps
`default_nettype none

module fdi_regs_top (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_link,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic fault_short,
    input wire logic fault_overtemp,
    input wire logic fault_overvolt,
    input wire logic flash_timeout,
    input wire logic flash_end,
    output logic [4:0] main_level,
    output logic [2:0] indicator_current_level,
    output logic timed_operation_select,
    output logic [3:0] flash_duration_code,
    output logic flash_trigger_bit,
    output logic torch_mode,
    output logic flash_armed,
    output logic converter_inhibit,
    output logic irq_n_out,
    output logic irq_n_oe_n
);
    function automatic logic fdi_is_torch(input logic [4:0] lvl);
        return (lvl != fdi_pkg::MAIN_LEVEL_OFF) && (lvl <= fdi_pkg::MAIN_TORCH_MAX);
    endfunction
    function automatic logic fdi_is_flash(input logic [4:0] lvl);
        return lvl >= fdi_pkg::MAIN_FLASH_MIN;
    endfunction
    function automatic logic [7:0] fdi_reg_read(input logic [7:0] addr, input logic [7:0] lvl,
                                                 input logic [4:0] tmr, input logic trig,
                                                 input logic [3:0] flags);
        logic [7:0] val;
        val = 8'h00;
        case (addr)
            fdi_pkg::OFS_LED_CURRENT_CONTROL: val = lvl;
            fdi_pkg::OFS_FLASH_TIMER_CONTROL: val = {3'h0, tmr};
            fdi_pkg::OFS_FLASH_TRIGGER: val = {7'h00, trig};
            fdi_pkg::OFS_FAULT_FLAGS: val = {4'h0, flags};
            default: val = 8'h00;
        endcase
        return val;
    endfunction
    // link domain reset: async assert, release synchronised to clk_link
    logic link_rst_s1_ff, link_rst_b_ff;
    always_ff @(posedge clk_link or negedge rst_b) begin
        if (!rst_b) begin
            link_rst_s1_ff <= 1'b0;
            link_rst_b_ff <= 1'b0;
        end else begin
            link_rst_s1_ff <= 1'b1;
            link_rst_b_ff <= link_rst_s1_ff;
        end
    end
    // pin synchronisers; third stage only feeds edge detection
    logic scl_s1_ff, scl_s2_ff, scl_s3_ff, sda_s1_ff, sda_s2_ff, sda_s3_ff;
    always_ff @(posedge clk_link or negedge link_rst_b_ff) begin
        if (!link_rst_b_ff) begin
            {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= 3'h7;
            {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= 3'h7;
        end else begin
            {scl_s1_ff, scl_s2_ff, scl_s3_ff} <= {scl_in, scl_s1_ff, scl_s2_ff};
            {sda_s1_ff, sda_s2_ff, sda_s3_ff} <= {sda_in, sda_s1_ff, sda_s2_ff};
        end
    end
    wire scl_rise = scl_s2_ff & ~scl_s3_ff;
    wire scl_fall = ~scl_s2_ff & scl_s3_ff;
    wire start_det = scl_s2_ff & scl_s3_ff & ~sda_s2_ff & sda_s3_ff;
    wire stop_det = scl_s2_ff & scl_s3_ff & sda_s2_ff & ~sda_s3_ff;
    // link state
    fdi_pkg::fdi_state_e state_ff, nxt_state;
    fdi_pkg::fdi_role_e role_ff, nxt_role;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [7:0] shift_ff, nxt_shift;
    logic [7:0] sub_ff, nxt_sub;
    logic rw_ff, nxt_rw;
    logic drv_ff, nxt_drv;
    logic req_tgl_ff, nxt_req_tgl;
    logic req_wr_ff, nxt_req_wr;
    logic [7:0] req_addr_ff, nxt_req_addr;
    logic [7:0] req_data_ff, nxt_req_data;
    logic [7:0] rbuf_ff;
    logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
    logic ack_tgl_ff;
    logic [7:0] rd_data_ff;
    wire addr_hit = shift_ff[7:1] == fdi_pkg::DEV_ADDR;
    wire byte_done = scl_fall && (cnt_ff == 4'h8);
    always_comb begin
        nxt_state = state_ff;
        nxt_role = role_ff;
        nxt_cnt = cnt_ff;
        nxt_shift = shift_ff;
        nxt_sub = sub_ff;
        nxt_rw = rw_ff;
        nxt_drv = drv_ff;
        nxt_req_tgl = req_tgl_ff;
        nxt_req_wr = req_wr_ff;
        nxt_req_addr = req_addr_ff;
        nxt_req_data = req_data_ff;
        if (start_det) begin
            // repeated start lands here too; subaddress is kept
            nxt_state = fdi_pkg::ST_RX;
            nxt_role = fdi_pkg::ROLE_ADDR;
            nxt_cnt = 4'h0;
            nxt_drv = 1'b0;
        end else if (stop_det) begin
            nxt_state = fdi_pkg::ST_IDLE;
            nxt_drv = 1'b0;
        end else begin
            case (state_ff)
                fdi_pkg::ST_RX: begin
                    if (scl_rise) begin
                        nxt_shift = {shift_ff[6:0], sda_s2_ff};
                        nxt_cnt = cnt_ff + 4'h1;
                    end else if (byte_done) begin
                        nxt_state = fdi_pkg::ST_ACK;
                        nxt_drv = 1'b1;
                        case (role_ff)
                            fdi_pkg::ROLE_ADDR: begin
                                if (!addr_hit) begin
                                    // foreign address: stay silent until the next start
                                    nxt_state = fdi_pkg::ST_IDLE;
                                    nxt_drv = 1'b0;
                                end else begin
                                    nxt_rw = shift_ff[0];
                                    nxt_role = shift_ff[0] ? fdi_pkg::ROLE_DATA : fdi_pkg::ROLE_SUB;
                                    if (shift_ff[0]) begin
                                        nxt_req_tgl = ~req_tgl_ff;
                                        nxt_req_wr = 1'b0;
                                        nxt_req_addr = sub_ff;
                                    end
                                end
                            end
                            fdi_pkg::ROLE_SUB: begin
                                nxt_sub = shift_ff;
                                nxt_role = fdi_pkg::ROLE_DATA;
                            end
                            default: begin
                                nxt_req_tgl = ~req_tgl_ff;
                                nxt_req_wr = 1'b1;
                                nxt_req_addr = sub_ff;
                                nxt_req_data = shift_ff;
                                nxt_sub = sub_ff + 8'h01;
                            end
                        endcase
                    end
                end
                fdi_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        nxt_cnt = 4'h0;
                        if (rw_ff) begin
                            // read data was fetched during the acknowledge bit
                            nxt_state = fdi_pkg::ST_TX;
                            nxt_shift = rbuf_ff;
                            nxt_drv = ~rbuf_ff[7];
                            nxt_sub = sub_ff + 8'h01;
                        end else begin
                            nxt_state = fdi_pkg::ST_RX;
                            nxt_drv = 1'b0;
                        end
                    end
                end
                fdi_pkg::ST_TX: begin
                    if (scl_fall) begin
                        nxt_cnt = cnt_ff + 4'h1;
                        if (cnt_ff == 4'h7) begin
                            nxt_state = fdi_pkg::ST_RACK;
                            nxt_drv = 1'b0;
                        end else begin
                            nxt_shift = {shift_ff[6:0], 1'b0};
                            nxt_drv = ~shift_ff[6];
                        end
                    end
                end
                fdi_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        if (!sda_s2_ff) begin
                            // controller wants more: fetch the next register
                            nxt_state = fdi_pkg::ST_ACK;
                            nxt_req_tgl = ~req_tgl_ff;
                            nxt_req_wr = 1'b0;
                            nxt_req_addr = sub_ff;
                        end else begin
                            nxt_state = fdi_pkg::ST_IDLE;
                        end
                    end
                end
                default: nxt_state = fdi_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_link or negedge link_rst_b_ff) begin
        if (!link_rst_b_ff) begin
            state_ff <= fdi_pkg::ST_IDLE;
            role_ff <= fdi_pkg::ROLE_ADDR;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            sub_ff <= 8'h00;
            rw_ff <= 1'b0;
            drv_ff <= 1'b0;
            req_tgl_ff <= 1'b0;
            req_wr_ff <= 1'b0;
            req_addr_ff <= 8'h00;
            req_data_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            role_ff <= nxt_role;
            cnt_ff <= nxt_cnt;
            shift_ff <= nxt_shift;
            sub_ff <= nxt_sub;
            rw_ff <= nxt_rw;
            drv_ff <= nxt_drv;
            req_tgl_ff <= nxt_req_tgl;
            req_wr_ff <= nxt_req_wr;
            req_addr_ff <= nxt_req_addr;
            req_data_ff <= nxt_req_data;
        end
    end
    // read data returns through the acknowledge toggle
    always_ff @(posedge clk_link or negedge link_rst_b_ff) begin
        if (!link_rst_b_ff) begin
            {ack_s1_ff, ack_s2_ff, ack_s3_ff} <= 3'h0;
            rbuf_ff <= 8'h00;
        end else begin
            {ack_s1_ff, ack_s2_ff, ack_s3_ff} <= {ack_tgl_ff, ack_s1_ff, ack_s2_ff};
            if (ack_s2_ff ^ ack_s3_ff) begin
                rbuf_ff <= rd_data_ff;
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = ~drv_ff;
    // system domain: request crossing and register bank
    logic req_s1_ff, req_s2_ff, req_s3_ff;
    logic fs_s1_ff, fs_s2_ff, ft_s1_ff, ft_s2_ff, fv_s1_ff, fv_s2_ff;
    logic [7:0] lvl_ff;
    logic [4:0] tmr_ff;
    logic trig_ff;
    logic [3:0] flags_ff;

    // request fields stay still for many clk_link cycles around the toggle
    wire op_go = req_s2_ff ^ req_s3_ff;
    wire wr_go = op_go & req_wr_ff;
    wire wr_lvl = wr_go && (req_addr_ff == fdi_pkg::OFS_LED_CURRENT_CONTROL);
    wire wr_tmr = wr_go && (req_addr_ff == fdi_pkg::OFS_FLASH_TIMER_CONTROL);
    wire wr_trig = wr_go && (req_addr_ff == fdi_pkg::OFS_FLASH_TRIGGER);
    wire flag_clear = wr_lvl && (req_data_ff == fdi_pkg::FAULT_RECOVER_VALUE);
    wire [3:0] flag_set = {fs_s2_ff, ft_s2_ff, flash_timeout, fv_s2_ff};
    // set beats clear so a fault in the recovery cycle is not lost
    wire [3:0] nxt_flags = (flags_ff & ~{4{flag_clear}}) | flag_set;
    wire [7:0] nxt_lvl = wr_lvl ? req_data_ff : lvl_ff;
    wire [4:0] nxt_tmr = wr_tmr ? req_data_ff[4:0] : tmr_ff;
    wire nxt_trig = wr_trig ? req_data_ff[fdi_pkg::TRIGGER_BIT] : (flash_end ? 1'b0 : trig_ff);
    wire [7:0] nxt_rd_data = op_go ? fdi_reg_read(req_addr_ff, lvl_ff, tmr_ff, trig_ff, flags_ff) : rd_data_ff;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {req_s1_ff, req_s2_ff, req_s3_ff} <= 3'h0;
            {fs_s1_ff, fs_s2_ff, ft_s1_ff, ft_s2_ff, fv_s1_ff, fv_s2_ff} <= 6'h00;
        end else begin
            {req_s1_ff, req_s2_ff, req_s3_ff} <= {req_tgl_ff, req_s1_ff, req_s2_ff};
            {fs_s1_ff, fs_s2_ff} <= {fault_short, fs_s1_ff};
            {ft_s1_ff, ft_s2_ff} <= {fault_overtemp, ft_s1_ff};
            {fv_s1_ff, fv_s2_ff} <= {fault_overvolt, fv_s1_ff};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lvl_ff <= fdi_pkg::RST_LED_CURRENT;
            tmr_ff <= fdi_pkg::RST_TIMER_CTRL;
            trig_ff <= fdi_pkg::RST_TRIGGER;
            flags_ff <= fdi_pkg::RST_FLAGS;
            rd_data_ff <= 8'h00;
            ack_tgl_ff <= 1'b0;
        end else begin
            lvl_ff <= nxt_lvl;
            tmr_ff <= nxt_tmr;
            trig_ff <= nxt_trig;
            flags_ff <= nxt_flags;
            rd_data_ff <= nxt_rd_data;
            ack_tgl_ff <= ack_tgl_ff ^ op_go;
        end
    end

    assign main_level = lvl_ff[fdi_pkg::MAIN_LEVEL_MSB:fdi_pkg::MAIN_LEVEL_LSB];
    assign indicator_current_level = lvl_ff[fdi_pkg::INDICATOR_CURRENT_LEVEL_MSB:fdi_pkg::INDICATOR_CURRENT_LEVEL_LSB];
    assign timed_operation_select = tmr_ff[fdi_pkg::TIMED_OP_BIT];
    assign flash_duration_code = tmr_ff[fdi_pkg::DURATION_MSB:fdi_pkg::DURATION_LSB];
    assign flash_trigger_bit = trig_ff;
    assign torch_mode = fdi_is_torch(main_level);
    assign flash_armed = fdi_is_flash(main_level);
    assign converter_inhibit = |flags_ff;
    assign irq_n_out = 1'b0;
    assign irq_n_oe_n = ~(|flags_ff);
    // checks
    a_irq_on_fault: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(fault_overvolt) |-> ##[2:3] (!irq_n_oe_n && converter_inhibit))
        else $error("overvoltage did not raise the interrupt");
    a_fault_recover: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (flag_clear && flag_set == 4'h0) |=> (flags_ff == 4'h0 && irq_n_oe_n && $stable(tmr_ff)))
        else $error("recovery write did not clear flags");
    a_status_readonly: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (wr_go && req_addr_ff == fdi_pkg::OFS_FAULT_FLAGS && flag_set == 4'h0) |=> $stable(flags_ff))
        else $error("status write changed flags");
    a_strobe_selfclear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (flash_end && !wr_trig) |=> !flash_trigger_bit)
        else $error("trigger bit survived strobe end");
    a_mode_decode: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !(torch_mode && flash_armed) && ((main_level == fdi_pkg::MAIN_LEVEL_OFF) == !(torch_mode || flash_armed)))
        else $error("main level decode inconsistent");
    a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (op_go && !req_wr_ff && req_addr_ff == fdi_pkg::OFS_FLASH_TIMER_CONTROL) |=> rd_data_ff[7:5] == 3'h0)
        else $error("reserved timer bits read nonzero");
    a_addr_match: assert property (@(posedge clk_link) disable iff (!link_rst_b_ff)
        (byte_done && state_ff == fdi_pkg::ST_RX && role_ff == fdi_pkg::ROLE_ADDR && !start_det && !stop_det)
        |=> (drv_ff == (shift_ff[7:1] == fdi_pkg::DEV_ADDR)))
        else $error("address acknowledge mismatch");
    a_sub_advance: assert property (@(posedge clk_link) disable iff (!link_rst_b_ff)
        ($changed(req_tgl_ff) && req_wr_ff) |-> (sub_ff == req_addr_ff + 8'h01) && !sda_oe_n)
        else $error("subaddress did not advance on write");
    a_restart_addr: assert property (@(posedge clk_link) disable iff (!link_rst_b_ff)
        (start_det && state_ff != fdi_pkg::ST_IDLE) |=> (state_ff == fdi_pkg::ST_RX && role_ff == fdi_pkg::ROLE_ADDR
        && cnt_ff == 4'h0) ##1 $stable(sub_ff))
        else $error("repeated start not taken as address");
    a_ack_crosses: assert property (@(posedge clk_sys) disable iff (!rst_b)
        op_go |=> $changed(ack_tgl_ff))
        else $error("request not answered");

    c_write_seen: cover property (@(posedge clk_sys) disable iff (!rst_b) wr_go ##[1:1000] wr_go);
    c_read_seen: cover property (@(posedge clk_sys) disable iff (!rst_b) op_go && !req_wr_ff);
    c_restart_seen: cover property (@(posedge clk_link) disable iff (!link_rst_b_ff)
        start_det && role_ff == fdi_pkg::ROLE_DATA);
    c_fault_recover: cover property (@(posedge clk_sys) disable iff (!rst_b) converter_inhibit ##1 flag_clear);
endmodule

`default_nettype wire

// File: verilog/fdi_pkg.sv
/*
 * Constants, states and register layout shared by the flash driver
 * two-wire target and its four-register control bank.
 * Assumes nothing of its surroundings; holds definitions only.
 */
package fdi_pkg;
    // 7-bit target address; the byte on the wire is {addr, rw}
    localparam logic [6:0] DEV_ADDR = 7'h30;

    localparam logic [7:0] OFS_LED_CURRENT_CONTROL = 8'h00;
    localparam logic [7:0] OFS_FLASH_TIMER_CONTROL = 8'h01;
    localparam logic [7:0] OFS_FLASH_TRIGGER = 8'h02;
    localparam logic [7:0] OFS_FAULT_FLAGS = 8'h03;

    // field positions
    localparam int MAIN_LEVEL_MSB = 7;
    localparam int MAIN_LEVEL_LSB = 3;
    localparam int INDICATOR_CURRENT_LEVEL_MSB = 2;
    localparam int INDICATOR_CURRENT_LEVEL_LSB = 0;
    localparam int TIMED_OP_BIT = 4;
    localparam int DURATION_MSB = 3;
    localparam int DURATION_LSB = 0;
    localparam int TRIGGER_BIT = 0;
    localparam int SHORT_FLAG_BIT = 3;
    localparam int OVERTEMP_FLAG_BIT = 2;
    localparam int TIMEOUT_FLAG_BIT = 1;
    localparam int OVERVOLT_FLAG_BIT = 0;

    // main level decode bounds
    localparam logic [4:0] MAIN_LEVEL_OFF = 5'h00;
    localparam logic [4:0] MAIN_TORCH_MAX = 5'h0B;
    localparam logic [4:0] MAIN_FLASH_MIN = 5'h0C;

    // values after reset
    localparam logic [7:0] RST_LED_CURRENT = 8'h00;
    localparam logic [4:0] RST_TIMER_CTRL = 5'h00;
    localparam logic RST_TRIGGER = 1'b0;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    // value written to the current register that recovers from a fault
    localparam logic [7:0] FAULT_RECOVER_VALUE = 8'h00;

    // bus rate and the shortest bit time it implies at the system clock
    localparam int SYS_CLK_HZ = 125_000_000;
    localparam int FAST_MODE_BPS = 400_000;
    localparam int SCL_PERIOD_SYS_CYC = (SYS_CLK_HZ + FAST_MODE_BPS - 1) / FAST_MODE_BPS;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACK = 3'b011,
        ST_TX = 3'b010,
        ST_RACK = 3'b110
    } fdi_state_e;

    typedef enum logic [1:0] {
        ROLE_ADDR = 2'b00,
        ROLE_SUB = 2'b01,
        ROLE_DATA = 2'b11
    } fdi_role_e;
endpackage

// File: tb/fdi_ctl_model.sv
/* Bus controller model: drives SCL and pulls SDA low.
   Assumes the bench resolves SDA with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module fdi_ctl_model (
    input wire logic clk,
    input wire logic sda_w,
    output logic scl,
    output logic sda_pull
);
    // quarter bit in clk cycles; 2528 ns bits stay under 400 kbit/s
    localparam int QTR = 79;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic q;
        repeat (QTR) @(posedge clk);
    endtask
    // only called on an idle bus or with scl low, so it doubles as repeated start
    task automatic start;
        sda_pull <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic stop;
        sda_pull <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b0;
        q();
    endtask
    // eight bits msb first, then ack_bit in the ninth slot
    task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] r, output logic acked);
        for (int i = 7; i >= -1; i--) begin
            sda_pull <= (i >= 0) ? ~d[i] : ~ack_bit;
            q();
            scl <= 1'b1;
            q();
            if (i >= 0) r[i] = sda_w;
            else acked = ~sda_w;
            q();
            scl <= 1'b0;
            q();
        end
    endtask
endmodule
`default_nettype wire

// File: tb/tb_flash_driver_i2c_regs.sv
/* Bench for the flash driver target and register bank, driven through the controller model.
   Assumes fdi_regs_top and fdi_ctl_model are compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module tb_flash_driver_i2c_regs;
    logic clk_sys, clk_link, rst_b, scl, sda_pull, sda_out, sda_oe_n, sda_w;
    logic irq_n_out, irq_n_oe_n, irq_w, timed_op, trig, torch, armed, conv, a1;
    logic fault_short, fault_overtemp, fault_overvolt, flash_timeout, flash_end;
    logic [4:0] main_level;
    logic [2:0] ind;
    logic [3:0] dur;
    logic [7:0] x8;
    logic [31:0] r;
    int miscompares, comparisons;
    assign sda_w = ~sda_pull & ((sda_oe_n === 1'b0) ? sda_out : 1'b1);
    assign irq_w = (irq_n_oe_n === 1'b0) ? irq_n_out : 1'b1;
    fdi_regs_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_link(clk_link), .scl_in(scl),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .fault_short(fault_short),
        .fault_overtemp(fault_overtemp), .fault_overvolt(fault_overvolt), .flash_timeout(flash_timeout),
        .flash_end(flash_end), .main_level(main_level), .indicator_current_level(ind),
        .timed_operation_select(timed_op), .flash_duration_code(dur), .flash_trigger_bit(trig),
        .torch_mode(torch), .flash_armed(armed), .converter_inhibit(conv), .irq_n_out(irq_n_out),
        .irq_n_oe_n(irq_n_oe_n));
    fdi_ctl_model ctl_u (.clk(clk_sys), .sda_w(sda_w), .scl(scl), .sda_pull(sda_pull));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // phase offset keeps the link clock unrelated to clk_sys
    initial begin
        clk_link = 1'b0;
        #3.7;
        forever #7.5 clk_link = ~clk_link;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] sub, input logic [31:0] d, input int n);
        logic [7:0] x;
        logic a;
        ctl_u.start();
        ctl_u.xfer(8'h60, 1'b1, x, a);
        chk(32'(a), 32'h1);
        ctl_u.xfer(sub, 1'b1, x, a);
        chk(32'(a), 32'h1);
        for (int i = 0; i < n; i++) begin
            ctl_u.xfer(d[31:24], 1'b1, x, a);
            chk(32'(a), 32'h1);
            d = d << 8;
        end
        ctl_u.stop();
    endtask
    task automatic rd(input logic [7:0] sub, input int n, output logic [31:0] v);
        logic [7:0] x;
        logic a;
        v = 32'h0;
        ctl_u.start();
        ctl_u.xfer(8'h60, 1'b1, x, a);
        ctl_u.xfer(sub, 1'b1, x, a);
        ctl_u.start();
        ctl_u.xfer(8'h61, 1'b1, x, a);
        chk(32'(a), 32'h1);
        for (int i = 0; i < n; i++) begin
            ctl_u.xfer(8'hFF, (i == n - 1), x, a);
            v = {v[23:0], x};
        end
        ctl_u.stop();
    endtask
    task automatic summarize;
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        rst_b = 1'b0;
        {fault_short, fault_overtemp, fault_overvolt, flash_timeout, flash_end} = 5'h00;
        miscompares = 0;
        comparisons = 0;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (20) @(posedge clk_sys);
        rd(8'h00, 4, r);
        chk(r, 32'h0);
        // fourth byte lands on the status register and must not stick
        wr(8'h00, 32'h5DFFFFFF, 4);
        chk(32'({main_level, ind, torch, armed}), 32'h176);
        chk(32'({timed_op, dur, trig}), 32'h3F);
        rd(8'h00, 4, r);
        chk(r, 32'h5D1F0100);
        ctl_u.start();
        ctl_u.xfer(8'h62, 1'b1, x8, a1);
        chk(32'(a1), 32'h0);
        ctl_u.stop();
        @(posedge clk_sys) flash_end <= 1'b1;
        @(posedge clk_sys) flash_end <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(32'(trig), 32'h0);
        fault_overvolt <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk(32'({irq_w, conv}), 32'h1);
        fault_overvolt <= 1'b0;
        fault_short <= 1'b1;
        fault_overtemp <= 1'b1;
        repeat (4) @(posedge clk_sys);
        fault_short <= 1'b0;
        fault_overtemp <= 1'b0;
        flash_timeout <= 1'b1;
        @(posedge clk_sys) flash_timeout <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(8'h03, 1, r);
        chk(r, 32'h0F);
        wr(8'h00, 32'h0, 1);
        chk(32'({irq_w, conv, timed_op, dur}), 32'h5F);
        wr(8'h00, 32'h60000000, 1);
        chk(32'({torch, armed}), 32'h1);
        summarize();
    end
endmodule
`default_nettype wire
